// ### busif_pkg.sv
// Package for the system bus interface pin block.
// Assumes a single clock domain (the bus clock) and an active-low async reset.
`default_nettype none
package busif_pkg;

  // ----------------------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------------------
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned HALF_W      = 16;
  localparam int unsigned ADDR_W      = 31;
  localparam int unsigned REGSEL_W    = 6;
  localparam int unsigned STATUS_W    = 3;
  localparam int unsigned RESET_CLKS  = 10;
  localparam logic [3:0]  RESET_CNT_MAX = 4'(RESET_CLKS);
  localparam logic [15:0] REG_RESET_VAL = 16'h0000;
  localparam logic [2:0]  STATUS_IDLE   = 3'h0;

  // Byte order chosen by the strap.
  typedef enum logic {
    ORDER_LITTLE = 1'b0,
    ORDER_BIG    = 1'b1
  } order_e;

  // Bus operation currently under way.
  typedef enum logic [2:0] {
    OP_IDLE   = 3'h0,
    OP_DMA_RD = 3'h1,
    OP_DMA_WR = 3'h3,
    OP_SLV_RD = 3'h2,
    OP_SLV_WR = 3'h6,
    OP_MEM    = 3'h7
  } op_e;

  // Sequencer states, Gray along idle -> own -> drive.
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_IDLE  = 2'b01,
    ST_OWN   = 2'b11,
    ST_XFER  = 2'b10
  } seq_e;

  // DMA request from the core.
  typedef struct packed {
    logic              valid;
    logic              write;
    logic              wide;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dma_req_s;

endpackage : busif_pkg

`default_nettype wire

// ### busif_pins.sv
// System bus interface pins: DMA master drive, register slave port, status code.
// Assumes MCLK is the bus clock and all pin inputs are synchronous to it.
//
// Summary of operation
// - Strap level selects byte order only; nothing else depends on it.
// - Strap high means big-endian; low means little-endian.
// - Master 16-bit transfers use low half; 32-bit use all lines.
// - Slave reads drive only low sixteen lines; upper half floats.
// - DMA address driven only after bus ownership, floated otherwise.
// - Address is word aligned; 31 lines, no least significant bit.
// - Reset held low enters reset state after ten clocks.
// - Bus status code follows the bus operation; a DMA code holds one clock past the transfer.
// - All DMA activity is timed from the bus clock.
// - Acknowledge driven low for select or memory request when available.
// - Register number latched on slave address strobe.
`timescale 1ns/1ps
`default_nettype none

module busif_pins
  import busif_pkg::*;
#(
  parameter logic [2:0] ST_CODE_IDLE  = STATUS_IDLE,
  parameter logic [2:0] ST_CODE_DMARD = 3'h1,
  parameter logic [2:0] ST_CODE_DMAWR = 3'h3,
  parameter logic [2:0] ST_CODE_SLVRD = 3'h2,
  parameter logic [2:0] ST_CODE_SLVWR = 3'h6,
  parameter logic [2:0] ST_CODE_MEM   = 3'h7
) (
  // Clock and reset.
  input  wire  logic                   MCLK,
  input  wire  logic                   RST_N,
  input  wire  logic                   RESET_PIN_N,
  // Strap.
  input  wire  logic                   ENDIAN_SELECT_STRAP,
  // Data lines, three signals per pin.
  input  wire  logic [DATA_W-1:0]      SYSTEM_DATA_LINES_I,
  output logic       [DATA_W-1:0]      SYSTEM_DATA_LINES_O,
  output logic       [DATA_W-1:0]      SYSTEM_DATA_LINES_OE,
  // Address lines.
  output logic       [ADDR_W-1:0]      DMA_ADDRESS_LINES_O,
  output logic                         DMA_ADDRESS_LINES_OE,
  // Slave port.
  input  wire  logic [REGSEL_W-1:0]    REGISTER_SELECT_LINES,
  input  wire  logic                   SLAVE_ADDRESS_STROBE_N,
  input  wire  logic                   CHIP_SELECT_N,
  input  wire  logic                   SLAVE_WRITE,
  input  wire  logic                   SHARED_MEMORY_REQUEST_N,
  input  wire  logic                   MEM_AVAILABLE,
  output logic                         SLAVE_MEMORY_ACKNOWLEDGE_N,
  // Core side.
  input  wire  busif_pkg::dma_req_s    DMA_REQ,
  input  wire  logic                   BUS_GRANT,
  output logic                         BUS_REQUEST,
  output logic                         DMA_DONE,
  output logic       [DATA_W-1:0]      DMA_RDATA,
  output logic       [HALF_W-1:0]      REG_RDATA_IN,
  output logic       [REGSEL_W-1:0]    REG_INDEX,
  output logic                         REG_WR_STB,
  output logic       [HALF_W-1:0]      REG_WDATA,
  input  wire  logic [HALF_W-1:0]      REG_RDATA,
  output logic                         BIG_ENDIAN,
  output logic                         IN_RESET,
  output logic       [STATUS_W-1:0]    BUS_STATUS_CODE
);
  import busif_pkg::*;

  // ----------------------------------------------------------------------------
  // Byte-lane swap
  // ----------------------------------------------------------------------------
  // Swaps bytes within each half when big-endian ordering is selected.
  function automatic logic [DATA_W-1:0] order_bytes(input logic [DATA_W-1:0] d,
                                                     input logic big);
    order_bytes = big ? {d[23:16], d[31:24], d[7:0], d[15:8]} : d;
  endfunction : order_bytes

  // ----------------------------------------------------------------------------
  // Reset delay and strap capture
  // ----------------------------------------------------------------------------
  logic [3:0] rcnt_r, rcnt_nxt;
  logic       inrst_r, inrst_nxt;
  logic       big_r, big_nxt;

  // The reset pin must stay low for ten bus clocks before state is cleared,
  // so a short glitch on the board does not wipe an ongoing DMA.
  always_comb begin
    rcnt_nxt  = rcnt_r;
    inrst_nxt = inrst_r;
    big_nxt   = ENDIAN_SELECT_STRAP;
    if (RESET_PIN_N) begin
      rcnt_nxt  = 4'h0;
      inrst_nxt = 1'b0;
    end else if (rcnt_r == RESET_CNT_MAX - 4'h1) begin
      inrst_nxt = 1'b1;
    end else begin
      rcnt_nxt = rcnt_r + 4'h1;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rcnt_r  <= 4'h0;
      inrst_r <= 1'b1;
      big_r   <= 1'b0;
    end else begin
      rcnt_r  <= rcnt_nxt;
      inrst_r <= inrst_nxt;
      big_r   <= big_nxt;
    end
  end
  // Both paths see the pins in the strapped order; one swap serves every reader.
  logic [DATA_W-1:0] din_sw, rrd_sw;
  assign din_sw = order_bytes(SYSTEM_DATA_LINES_I, big_r);
  assign rrd_sw = order_bytes({16'h0000, REG_RDATA}, big_r);

  // ----------------------------------------------------------------------------
  // DMA master sequencer
  // ----------------------------------------------------------------------------
  seq_e              st_r, st_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic              wr_r, wr_nxt, wide_r, wide_nxt, done_r, done_nxt;

  // Runs on MCLK only, which is the bus clock.
  always_comb begin
    st_nxt   = st_r;
    addr_nxt = addr_r;
    wd_nxt   = wd_r;
    rd_nxt   = rd_r;
    wr_nxt   = wr_r;
    wide_nxt = wide_r;
    done_nxt = 1'b0;
    case (st_r)
      ST_RESET: st_nxt = ST_IDLE;
      ST_IDLE: begin
        if (DMA_REQ.valid) begin
          addr_nxt = DMA_REQ.addr;
          wd_nxt   = order_bytes(DMA_REQ.wdata, big_r);
          wr_nxt   = DMA_REQ.write;
          wide_nxt = DMA_REQ.wide;
          st_nxt   = ST_OWN;
        end
      end
      ST_OWN: if (BUS_GRANT) st_nxt = ST_XFER;
      ST_XFER: begin
        // Narrow reads capture only the low half.
        rd_nxt   = wide_r ? din_sw : {16'h0000, din_sw[HALF_W-1:0]};
        done_nxt = 1'b1;
        st_nxt   = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (inrst_r) st_nxt = ST_RESET;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r   <= ST_RESET;
      addr_r <= '0;
      wd_r   <= '0;
      rd_r   <= '0;
      wr_r   <= 1'b0;
      wide_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      addr_r <= addr_nxt;
      wd_r   <= wd_nxt;
      rd_r   <= rd_nxt;
      wr_r   <= wr_nxt;
      wide_r <= wide_nxt;
      done_r <= done_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Slave port
  // ----------------------------------------------------------------------------
  logic [REGSEL_W-1:0] idx_r, idx_nxt;
  logic                ack_r, ack_nxt;
  logic [HALF_W-1:0]   sd_r, sd_nxt;
  logic                wstb_r, wstb_nxt;

  // The select and memory request are mutually exclusive by board contract,
  // so one acknowledge serves both without arbitration here.
  always_comb begin
    idx_nxt  = idx_r;
    sd_nxt   = sd_r;
    wstb_nxt = 1'b0;
    if (!SLAVE_ADDRESS_STROBE_N) idx_nxt = REGISTER_SELECT_LINES;
    ack_nxt = !inrst_r && ((!CHIP_SELECT_N && st_r != ST_XFER)
              || (!SHARED_MEMORY_REQUEST_N && MEM_AVAILABLE));
    if (!CHIP_SELECT_N && ack_nxt && !ack_r) begin
      sd_nxt   = rrd_sw[HALF_W-1:0];
      wstb_nxt = SLAVE_WRITE;
    end
    if (inrst_r) sd_nxt = REG_RESET_VAL;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      idx_r  <= '0;
      ack_r  <= 1'b0;
      sd_r   <= REG_RESET_VAL;
      wstb_r <= 1'b0;
    end else begin
      idx_r  <= idx_nxt;
      ack_r  <= ack_nxt;
      sd_r   <= sd_nxt;
      wstb_r <= wstb_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Pin drive and status
  // ----------------------------------------------------------------------------
  logic slv_rd;
  logic [2:0] stat_r, stat_nxt;
  assign slv_rd = ack_r && !CHIP_SELECT_N && !SLAVE_WRITE;

  // Status table is a parameter set so a board can remap codes.
  always_comb begin
    stat_nxt = ST_CODE_IDLE;
    if (st_nxt == ST_XFER || st_r == ST_XFER)
      stat_nxt = wr_nxt ? ST_CODE_DMAWR : ST_CODE_DMARD;
    else if (ack_nxt && !CHIP_SELECT_N)
      stat_nxt = SLAVE_WRITE ? ST_CODE_SLVWR : ST_CODE_SLVRD;
    else if (ack_nxt)
      stat_nxt = ST_CODE_MEM;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) stat_r <= STATUS_IDLE;
    else        stat_r <= stat_nxt;
  end

  // Address only while the bus is owned.
  assign DMA_ADDRESS_LINES_O  = addr_r;
  assign DMA_ADDRESS_LINES_OE = (st_r == ST_XFER);
  // Master writes drive both or low half; slave reads low half only.
  assign SYSTEM_DATA_LINES_O  = (st_r == ST_XFER) ? wd_r : {16'h0000, sd_r};
  assign SYSTEM_DATA_LINES_OE = (st_r == ST_XFER && wr_r)
                                ? {{HALF_W{wide_r}}, {HALF_W{1'b1}}}
                                : {{HALF_W{1'b0}}, {HALF_W{slv_rd}}};
  assign SLAVE_MEMORY_ACKNOWLEDGE_N = !ack_r;
  assign BUS_REQUEST = (st_r == ST_OWN);
  assign DMA_DONE    = done_r;
  assign DMA_RDATA   = rd_r;
  assign REG_RDATA_IN = sd_r;
  assign REG_INDEX   = idx_r;
  assign REG_WR_STB  = wstb_r;
  assign REG_WDATA   = din_sw[HALF_W-1:0];
  assign BIG_ENDIAN  = big_r;
  assign IN_RESET    = inrst_r;
  assign BUS_STATUS_CODE = stat_r;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  strap_order_a: assert property (##1 BIG_ENDIAN == $past(ENDIAN_SELECT_STRAP))
    else $error("Byte order does not follow strap.");
  upper_float_a: assert property (st_r != ST_XFER |-> ~|SYSTEM_DATA_LINES_OE[31:16])
    else $error("Upper data lines driven during slave access.");
  addr_own_a: assert property (DMA_ADDRESS_LINES_OE |-> $past(BUS_GRANT))
    else $error("Address driven without ownership.");
  narrow_half_a: assert property (DMA_ADDRESS_LINES_OE && wr_r && !wide_r
                                  |-> SYSTEM_DATA_LINES_OE == 32'h0000ffff)
    else $error("Narrow write drives wrong lanes.");
  reset_delay_a: assert property ((!RESET_PIN_N)[*8] ##1 !RESET_PIN_N ##1 !RESET_PIN_N
                                  |=> IN_RESET)
    else $error("Reset state not reached after ten clocks.");
  reset_early_a: assert property ($rose(!RESET_PIN_N) && !IN_RESET |=> !IN_RESET)
    else $error("Reset state entered too early.");
  ack_cause_a: assert property (!SLAVE_MEMORY_ACKNOWLEDGE_N |->
                                $past(!CHIP_SELECT_N || !SHARED_MEMORY_REQUEST_N))
    else $error("Acknowledge without request.");
  idx_latch_a: assert property (!SLAVE_ADDRESS_STROBE_N && !IN_RESET
                                |=> REG_INDEX == $past(REGISTER_SELECT_LINES))
    else $error("Register number not latched.");
  idle_code_a: assert property (st_r == ST_IDLE && SLAVE_MEMORY_ACKNOWLEDGE_N
                                && $past(st_r) == ST_IDLE && !$past(ack_nxt)
                                |-> BUS_STATUS_CODE == ST_CODE_IDLE)
    else $error("Idle status code wrong.");

  dma_cov: cover property (st_r == ST_OWN ##1 st_r == ST_XFER);
  slv_cov: cover property ($fell(SLAVE_MEMORY_ACKNOWLEDGE_N) && !CHIP_SELECT_N);
  mem_cov: cover property ($fell(SLAVE_MEMORY_ACKNOWLEDGE_N) && !SHARED_MEMORY_REQUEST_N);
  rst_cov: cover property ($rose(IN_RESET));

endmodule : busif_pins

`default_nettype wire

// ### busif_host_model.sv
// Host side model: bus arbiter, system memory and data-line resolver.
// Assumes one clock; the bench drives host data through host_en and host_data.
`timescale 1ns/1ps
`default_nettype none

module busif_host_model
  import busif_pkg::*;
(
  // Clock and arbiter.
  input  wire logic              clk,
  input  wire logic [3:0]        grant_wait,
  input  wire logic              bus_request,
  output logic                   bus_grant = 1'b0,
  // Pins of the block.
  input  wire logic [ADDR_W-1:0] addr_o,
  input  wire logic              addr_oe,
  input  wire logic [DATA_W-1:0] dev_o,
  input  wire logic [DATA_W-1:0] dev_oe,
  // Host CPU data.
  input  wire logic              host_en,
  input  wire logic [DATA_W-1:0] host_data,
  output logic      [DATA_W-1:0] data_i
);
  logic [DATA_W-1:0] last_r = '0;
  logic [DATA_W-1:0] mem_word;
  logic [3:0]        wait_r = 4'h0;

  // ---------------------------------------------------------------------------
  // Data lines
  // ---------------------------------------------------------------------------
  // Memory answers while the address is out; a released line shows the inverse of its
  // last level, so a design that samples a floating line cannot pass by luck.
  assign mem_word = {1'b1, addr_o} ^ 32'h5a5a_3c3c;
  always_comb begin
    for (int b = 0; b < DATA_W; b++) begin
      if (dev_oe[b]) data_i[b] = dev_o[b];
      else if (host_en) data_i[b] = host_data[b];
      else if (addr_oe) data_i[b] = mem_word[b];
      else data_i[b] = ~last_r[b];
    end
  end

  // ---------------------------------------------------------------------------
  // Arbiter
  // ---------------------------------------------------------------------------
  // Ownership is granted after a programmable stall and held while requested.
  always @(posedge clk) begin
    last_r <= data_i;
    if (!bus_request) begin
      wait_r    <= 4'h0;
      bus_grant <= #1 1'b0;
    end else if (wait_r >= grant_wait) begin
      bus_grant <= #1 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule : busif_host_model

`default_nettype wire

// ### system_bus_interface_pins_test.sv
// Testbench for the system bus interface pins, with the host model on the far side.
// Assumes a 25 MHz bus clock and inputs driven 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none

module system_bus_interface_pins_test;
  import busif_pkg::*;
  logic        mclk = 1'b0, rst_n = 1'b0, rpin_n = 1'b1, strap = 1'b0, sas_n = 1'b1;
  logic        cs_n = 1'b1, slv_wr = 1'b0, shared_memory_request_n = 1'b1, mem_av = 1'b0, host_en = 1'b0;
  logic [5:0]  ra = 6'h00;
  logic [15:0] reg_rd = 16'h0000;
  logic [3:0]  gwait = 4'h1;
  logic [31:0] host_data = 32'h0000_0000;
  dma_req_s    req = '0;
  logic [31:0] d_i, d_o, d_oe, dma_rd;
  logic [30:0] a_o;
  logic [15:0] rd_in, reg_wd;
  logic [5:0]  reg_idx;
  logic [2:0]  status;
  logic        a_oe, ack_n, grant, bus_req, done, wr_stb, big, in_rst;
  int          num_errors = 0, compares = 0;

  always #20 mclk = ~mclk;

  busif_pins uut (.MCLK(mclk), .RST_N(rst_n), .RESET_PIN_N(rpin_n),
    .ENDIAN_SELECT_STRAP(strap), .SYSTEM_DATA_LINES_I(d_i), .SYSTEM_DATA_LINES_O(d_o),
    .SYSTEM_DATA_LINES_OE(d_oe), .DMA_ADDRESS_LINES_O(a_o), .DMA_ADDRESS_LINES_OE(a_oe),
    .REGISTER_SELECT_LINES(ra), .SLAVE_ADDRESS_STROBE_N(sas_n), .CHIP_SELECT_N(cs_n),
    .SLAVE_WRITE(slv_wr), .SHARED_MEMORY_REQUEST_N(shared_memory_request_n), .MEM_AVAILABLE(mem_av),
    .SLAVE_MEMORY_ACKNOWLEDGE_N(ack_n), .DMA_REQ(req), .BUS_GRANT(grant),
    .BUS_REQUEST(bus_req), .DMA_DONE(done), .DMA_RDATA(dma_rd), .REG_RDATA_IN(rd_in),
    .REG_INDEX(reg_idx), .REG_WR_STB(wr_stb), .REG_WDATA(reg_wd), .REG_RDATA(reg_rd),
    .BIG_ENDIAN(big), .IN_RESET(in_rst), .BUS_STATUS_CODE(status));

  busif_host_model host (.clk(mclk), .grant_wait(gwait), .bus_request(bus_req),
    .bus_grant(grant), .addr_o(a_o), .addr_oe(a_oe), .dev_o(d_o), .dev_oe(d_oe),
    .host_en(host_en), .host_data(host_data), .data_i(d_i));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // One comparison kind: narrow results are widened by the caller.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chk

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick

  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // One DMA transfer; the wait for ownership is bounded.
  task automatic dma(input logic wr, input logic wide, input logic [30:0] ad,
                     input logic [31:0] wd);
    int          n;
    logic [31:0] msk;
    msk = wide ? 32'hffff_ffff : 32'h0000_ffff;
    n   = 0;
    req = '{valid: 1'b1, write: wr, wide: wide, addr: ad, wdata: wd};
    tick();
    req.valid = 1'b0;
    chk(32'(bus_req), 32'h1, "bus request");
    chk(32'(a_oe), 32'h0, "address before grant");
    while (a_oe !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    if (n == 20) begin
      num_errors++;
      $display("BAD %0t ownership timeout", $time);
      end_of_test();
    end
    chk(32'(a_o), 32'(ad), "word address");
    chk(d_oe, wr ? msk : 32'h0, "data enables");
    chk(d_o & msk & {32{wr}}, wd & msk & {32{wr}}, "write data");
    chk(32'(status), wr ? 32'(OP_DMA_WR) : 32'(OP_DMA_RD), "status");
    tick();
    chk(32'(done), 32'h1, "done");
    chk(dma_rd & msk & {32{!wr}}, ({1'b1, ad} ^ 32'h5a5a_3c3c) & msk & {32{!wr}},
        "read data");
    chk(32'(a_oe), 32'h0, "address released");
  endtask : dma

  // One register access; read data is byte-swapped when the strap is high.
  task automatic slave(input logic wr, input logic [5:0] idx, input logic [15:0] val);
    logic [15:0] want;
    want      = strap ? {val[7:0], val[15:8]} : val;
    ra        = idx;
    sas_n     = 1'b0;
    cs_n      = 1'b0;
    slv_wr    = wr;
    host_en   = wr;
    host_data = {16'h0000, val};
    reg_rd    = val;
    tick();
    chk(32'(ack_n), 32'h0, "slave ack");
    chk(32'(reg_idx), 32'(idx), "register index");
    chk(d_oe, wr ? 32'h0 : 32'h0000_ffff, "slave enables");
    if (wr) chk(32'({wr_stb, reg_wd}), 32'({1'b1, val}), "reg write");
    else chk(32'(d_o[15:0]), 32'(want), "reg read");
    if (!wr) chk(32'(rd_in), 32'(want), "reg data held");
    chk(32'(status), wr ? 32'(OP_SLV_WR) : 32'(OP_SLV_RD), "slave status");
    cs_n    = 1'b1;
    sas_n   = 1'b1;
    host_en = 1'b0;
    slv_wr  = 1'b0;
    tick();
    tick();
    chk(32'(ack_n), 32'h1, "ack released");
  endtask : slave

  // Shared memory request, kept well apart from any chip select.
  task automatic mem(input logic av);
    tick();
    mem_av = av;
    shared_memory_request_n = 1'b0;
    tick();
    chk(32'(ack_n), 32'(!av), "memory ack");
    chk(32'(status), av ? 32'(OP_MEM) : 32'(OP_IDLE), "memory status");
    shared_memory_request_n = 1'b1;
    mem_av = 1'b0;
    tick();
    tick();
    chk(32'(ack_n), 32'h1, "memory ack released");
  endtask : mem

  // Reset pin held low, with a refused select while the device is in reset.
  task automatic reset_pin();
    rpin_n = 1'b0;
    repeat (8) tick();
    chk(32'(in_rst), 32'h0, "reset too early");
    repeat (4) tick();
    chk(32'(in_rst), 32'h1, "reset entered");
    cs_n = 1'b0;
    tick();
    chk(32'(ack_n), 32'h1, "select refused in reset");
    cs_n   = 1'b1;
    rpin_n = 1'b1;
    repeat (3) tick();
    chk(32'(in_rst), 32'h0, "reset left");
  endtask : reset_pin

  // Pins straight after reset: nothing driven, no acknowledge, idle code.
  task automatic idle_after_reset();
    tick();
    tick();
    chk(d_oe | 32'(a_oe), 32'h0, "idle enables");
    chk(32'({ack_n, status}), 32'({1'b1, STATUS_IDLE}), "idle status");
  endtask : idle_after_reset

  // Strap change; the registered byte order follows one clock later.
  task automatic strap_level(input logic s);
    strap = s;
    tick();
    tick();
    chk(32'(big), 32'(s), "strap order");
  endtask : strap_level

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    idle_after_reset();
    dma(1'b1, 1'b1, 31'h1234_5678, 32'hdead_beef);
    dma(1'b1, 1'b0, 31'h0000_0001, 32'hffff_a55a);
    gwait = 4'h4;
    dma(1'b0, 1'b1, 31'h7fff_fffe, 32'h0);
    gwait = 4'h0;
    dma(1'b0, 1'b0, 31'h0000_0000, 32'h0);
    slave(1'b0, 6'h3f, 16'h1234);
    slave(1'b1, 6'h00, 16'hc3a5);
    mem(1'b1);
    mem(1'b0);
    strap_level(1'b1);
    slave(1'b0, 6'h15, 16'h12ab);
    strap_level(1'b0);
    reset_pin();
    end_of_test();
  end
endmodule : system_bus_interface_pins_test

`default_nettype wire
